// [ir_remote_pulse_spacing_encoder.sv]
// Infrared remote encoder: key matrix scan, strap address and pulse-spacing output
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ir_encoder_defs.svh"
module ir_remote_pulse_spacing_encoder #(
	parameter int HALF_DIV = `CLK_FREQ_HZ / (2 * `OSC_FREQ_HZ),
	parameter int UNIT_OSC = `UNIT_OSC,
	parameter int WORD_SHORT_OSC = `WORD_SHORT_OSC,
	parameter int WORD_LONG_OSC = `WORD_LONG_OSC,
	parameter int SCAN_STEP_OSC = `SCAN_STEP_OSC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [`NUM_LINES-1:0] i_matrix_sense_n,
	output logic [`NUM_LINES-1:0] o_matrix_drive_out,
	output logic [`NUM_LINES-1:0] o_matrix_drive_oe,
	input wire logic i_address_mode_strap_input,
	output logic o_strap_pullup_en,
	output logic o_strap_pulldown_en,
	output logic o_ir_code_output,
	output logic o_resonator_run
);
	// ----------------------------------------------------------------
	// Derived counts
	// ----------------------------------------------------------------
	localparam logic [11:0] SPACE_ZERO = 12'(`ZERO_UNITS * UNIT_OSC);
	localparam logic [11:0] SPACE_ONE = 12'(`ONE_UNITS * UNIT_OSC);
	localparam logic [15:0] WORD_SHORT = 16'(WORD_SHORT_OSC);
	localparam logic [15:0] WORD_LONG = 16'(WORD_LONG_OSC);
	localparam logic [2:0] STEP_LAST = 3'(SCAN_STEP_OSC - 1);

	ir_encoder_pkg::tx_state_type state_q;
	logic [`NUM_LINES-1:0] sense_n_s;
	logic strap_s;
	logic half_tick;
	logic full_tick;
	logic [2:0] step_q;
	logic [2:0] step_cnt_q;
	logic first_scan_q;
	logic [`NUM_LINES-1:0] hits_q;
	logic key_found_q;
	logic [2:0] key_drv_q;
	logic [2:0] key_sense_q;
	logic [5:0] cmd_q;
	logic [3:0] addr_q;
	logic long_q;
	logic mod_q;
	logic [1:0] toggle_q;
	logic [11:0] shift_q;
	logic [3:0] bits_left_q;
	logic [3:0] ph_cnt_q;
	logic [11:0] sp_cnt_q;
	logic [15:0] word_cnt_q;
	logic out_q;
	logic [15:0] words_q;
	logic enable_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [`NUM_LINES-1:0] drive_oe_q;
	logic pullup_q;
	logic pulldown_q;

	// ----------------------------------------------------------------
	// Pin synchronisers and oscillator
	// ----------------------------------------------------------------
	in_sync2 #(
		.WIDTH(`NUM_LINES),
		.RESET_VAL({`NUM_LINES{1'b1}})
	) u_sense_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_async(i_matrix_sense_n),
		.o_sync(sense_n_s)
	);

	in_sync2 #(
		.WIDTH(1),
		.RESET_VAL(1'b0)
	) u_strap_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_async(i_address_mode_strap_input),
		.o_sync(strap_s)
	);

	osc_tick_gen #(
		.HALF_DIV(HALF_DIV)
	) u_osc (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_run(state_q != ir_encoder_pkg::st_standby),
		.o_half_tick(half_tick),
		.o_full_tick(full_tick)
	);

	// ----------------------------------------------------------------
	// Scan decoding
	// ----------------------------------------------------------------
	// strap pattern to address bits, {long, S3..S0}
	function automatic logic [4:0] decode_strap(input logic [5:0] hits);
		logic [2:0] lo;
		logic [2:0] hi;
		logic [2:0] n;
		logic [2:0] d;
		lo = 3'h0;
		hi = 3'h0;
		n = 3'h0;
		d = 3'h0;
		for (int k = 5; k >= 0; k--) begin
			if (hits[k]) begin
				lo = k[2:0];
				n = n + 3'h1;
			end
		end
		for (int k = 0; k < 6; k++) begin
			if (hits[k]) begin
				hi = k[2:0];
			end
		end
		d = hi - 3'h2;
		if (n == 3'h1) begin
			decode_strap = {2'b00, lo};
		end else if (n == 3'h2 && lo <= 3'h3 && hi >= 3'h2) begin
			decode_strap = {1'b1, d[0], d[1], lo[1:0]};
		end else begin
			// Unlisted patterns fall back to the unstrapped address
			decode_strap = {2'b00, `ADDR_NONE};
		end
	endfunction

	// lowest low sense line; lines five and six together form index seven
	function automatic logic [2:0] sense_index(input logic [`NUM_LINES-1:0] low);
		sense_index = 3'h0;
		for (int k = `NUM_LINES - 1; k >= 0; k--) begin
			if (low[k]) begin
				sense_index = k[2:0];
			end
		end
		if (low[5] && low[6]) begin
			sense_index = `TRIPLE_SENSE;
		end
	endfunction

	logic step_end;
	logic [`NUM_LINES-1:0] step_onehot;
	logic [`NUM_LINES-1:0] scan_hits;
	logic scan_found;
	logic [2:0] scan_drv;
	logic [2:0] scan_sense;
	logic [5:0] scan_cmd;
	logic [4:0] strap_code;
	logic [3:0] eff_addr;
	logic eff_long;
	logic new_press;
	logic [1:0] tog_next;
	logic [11:0] word_bits;
	logic [15:0] word_len;
	logic [11:0] space_target;
	logic [3:0] pulse_halves;

	assign step_end = full_tick && (step_cnt_q == STEP_LAST);
	assign step_onehot = `NUM_LINES'(1) << step_q;
	// with the pull-up on, a strapped driver pulls the strap input low
	assign scan_hits = hits_q | (step_onehot & {`NUM_LINES{~strap_s}});
	assign scan_found = key_found_q || (|(~sense_n_s));
	assign scan_drv = key_found_q ? key_drv_q : step_q;
	assign scan_sense = key_found_q ? key_sense_q : sense_index(~sense_n_s);
	// key number is driver plus eight times sense
	assign scan_cmd = {scan_sense, scan_drv};
	// strap code spans twenty groups, command six bits
	// address from the drivers seen on the strap input
	assign strap_code = decode_strap(scan_hits[5:0]);
	// after the first scan the latched address is reused
	assign eff_addr = first_scan_q ? strap_code[3:0] : addr_q;
	assign eff_long = first_scan_q ? strap_code[4] : long_q;
	// a new key or a fresh wake is a new press
	assign new_press = first_scan_q || (scan_cmd != cmd_q);
	// toggle bits change state for a new press
	assign tog_next = new_press ? toggle_q + 2'h1 : toggle_q;
	// address top bit only for long addresses
	assign word_bits = eff_long ? {tog_next, eff_addr, scan_cmd} :
		{tog_next, eff_addr[2:0], scan_cmd, 1'b0};
	assign word_len = long_q ? WORD_LONG : WORD_SHORT;
	// zero spans two units, one spans three
	assign space_target = shift_q[11] ? SPACE_ONE : SPACE_ZERO;
	// flashed or modulated pulse length in half periods
	assign pulse_halves = mod_q ? `MOD_HALVES : `FLASH_HALVES;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ir_encoder_pkg::st_standby;
			step_q <= 3'h0;
			step_cnt_q <= 3'h0;
			first_scan_q <= 1'b1;
			hits_q <= '0;
			key_found_q <= 1'b0;
			key_drv_q <= 3'h0;
			key_sense_q <= 3'h0;
			cmd_q <= 6'h00;
			addr_q <= {1'b0, `ADDR_NONE};
			long_q <= 1'b0;
			mod_q <= 1'b0;
			toggle_q <= 2'h0;
			shift_q <= 12'h000;
			bits_left_q <= 4'h0;
			ph_cnt_q <= 4'h0;
			sp_cnt_q <= 12'h000;
			word_cnt_q <= 16'h0000;
			words_q <= 16'h0000;
		end else if (i_ce) begin
			if (full_tick) begin
				sp_cnt_q <= sp_cnt_q + 12'h001;
				word_cnt_q <= word_cnt_q + 16'h0001;
			end
			case (state_q)
				ir_encoder_pkg::st_standby: begin
					step_q <= 3'h0;
					step_cnt_q <= 3'h0;
					hits_q <= '0;
					key_found_q <= 1'b0;
					first_scan_q <= 1'b1;
					// a low sense line wakes the device
					// the strap input has no path to wake-up
					if (enable_q && (|(~sense_n_s))) begin
						state_q <= ir_encoder_pkg::st_scan;
					end
				end
				ir_encoder_pkg::st_scan: begin
					if (full_tick) begin
						step_cnt_q <= step_cnt_q + 3'h1;
					end
					if (step_end) begin
						step_cnt_q <= 3'h0;
						hits_q <= scan_hits;
						key_found_q <= scan_found;
						key_drv_q <= scan_drv;
						key_sense_q <= scan_sense;
						step_q <= step_q + 3'h1;
						if (step_q == `LAST_STEP) begin
							step_q <= 3'h0;
							hits_q <= '0;
							key_found_q <= 1'b0;
							// released key ends after the finished word
							if (!scan_found) begin
								state_q <= ir_encoder_pkg::st_standby;
							end else begin
								// address latched on the first scan only
								if (first_scan_q) begin
									addr_q <= strap_code[3:0];
									long_q <= strap_code[4];
									// driver six on the strap selects modulation
									mod_q <= scan_hits[`STRAP_MODE_LINE];
								end
								cmd_q <= scan_cmd;
								toggle_q <= tog_next;
								shift_q <= word_bits;
								bits_left_q <= eff_long ? `BITS_LONG : `BITS_SHORT;
								first_scan_q <= 1'b0;
								if (first_scan_q) begin
									state_q <= ir_encoder_pkg::st_pulse;
									ph_cnt_q <= 4'h0;
									sp_cnt_q <= 12'h000;
									word_cnt_q <= 16'h0000;
									words_q <= words_q + 16'h0001;
								end else begin
									state_q <= ir_encoder_pkg::st_hold;
								end
							end
						end
					end
				end
				ir_encoder_pkg::st_hold: begin
					// next word starts one word period after the last
					if (full_tick && (word_cnt_q >= word_len - 16'h0001)) begin
						state_q <= ir_encoder_pkg::st_pulse;
						ph_cnt_q <= 4'h0;
						sp_cnt_q <= 12'h000;
						word_cnt_q <= 16'h0000;
						words_q <= words_q + 16'h0001;
					end
				end
				ir_encoder_pkg::st_pulse: begin
					if (half_tick) begin
						ph_cnt_q <= ph_cnt_q + 4'h1;
						if (ph_cnt_q + 4'h1 == pulse_halves) begin
							state_q <= (bits_left_q == 4'h0) ?
								ir_encoder_pkg::st_scan : ir_encoder_pkg::st_gap;
						end
					end
				end
				ir_encoder_pkg::st_gap: begin
					// bit ends at the next leading edge
					if (full_tick && (sp_cnt_q == space_target - 12'h001)) begin
						state_q <= ir_encoder_pkg::st_pulse;
						ph_cnt_q <= 4'h0;
						sp_cnt_q <= 12'h000;
						shift_q <= {shift_q[10:0], 1'b0};
						bits_left_q <= bits_left_q - 4'h1;
					end
				end
				default: begin
					state_q <= ir_encoder_pkg::st_standby;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Code output shaping
	// ----------------------------------------------------------------
	logic [3:0] ph_next;
	assign ph_next = ph_cnt_q + 4'h1;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_q <= 1'b0;
		end else if (i_ce) begin
			if (state_q == ir_encoder_pkg::st_pulse) begin
				if (half_tick) begin
					// carrier toggles each half oscillator period
					if (ph_next == pulse_halves) begin
						out_q <= 1'b0;
					end else begin
						out_q <= mod_q ? ~ph_next[0] : 1'b1;
					end
				end
			end else if ((state_q == ir_encoder_pkg::st_gap &&
				full_tick && sp_cnt_q == space_target - 12'h001) ||
				(state_q == ir_encoder_pkg::st_hold && full_tick &&
				word_cnt_q >= word_len - 16'h0001) ||
				(state_q == ir_encoder_pkg::st_scan && step_end &&
				step_q == `LAST_STEP && scan_found && first_scan_q)) begin
				// leading edge drives the output high
				out_q <= 1'b1;
			end else begin
				out_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Matrix drivers and strap pulls
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			drive_oe_q <= {`NUM_LINES{1'b1}};
			pullup_q <= 1'b0;
			pulldown_q <= 1'b1;
		end else if (i_ce) begin
			// drivers conduct except while one is selected in a scan
			drive_oe_q <= (state_q == ir_encoder_pkg::st_scan) ?
				step_onehot : {`NUM_LINES{1'b1}};
			// standby holds only the pull-down on
			pulldown_q <= (state_q == ir_encoder_pkg::st_standby);
			pullup_q <= (state_q != ir_encoder_pkg::st_standby);
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave, one wait state per access
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			enable_q <= `CTRL_ENABLE_RESET;
		end else if (i_ce) begin
			ack_q <= (i_avs_read || i_avs_write) && !ack_q;
			if (i_avs_read && !ack_q) begin
				rdata_q <= 32'h0000_0000;
				if (i_avs_address == `REG_CTRL) begin
					rdata_q[`CTRL_ENABLE_BIT] <= enable_q;
				end else if (i_avs_address == `REG_STATUS) begin
					rdata_q[`STAT_BUSY_BIT] <= (state_q != ir_encoder_pkg::st_standby);
					rdata_q[`STAT_MOD_BIT] <= mod_q;
					rdata_q[`STAT_LONG_BIT] <= long_q;
					rdata_q[`STAT_ADDR_LSB +: 4] <= addr_q;
					rdata_q[`STAT_CMD_LSB +: 6] <= cmd_q;
					rdata_q[`STAT_TOG_LSB +: 2] <= toggle_q;
				end else if (i_avs_address == `REG_WORDS) begin
					rdata_q[15:0] <= words_q;
				end
			end
			// Disable only blocks wake-up; a word in flight still completes
			if (i_avs_write && ack_q && i_avs_address == `REG_CTRL) begin
				enable_q <= i_avs_writedata[`CTRL_ENABLE_BIT];
			end
		end
	end

	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
	assign o_avs_readdata = rdata_q;
	assign o_matrix_drive_out = '0;
	assign o_matrix_drive_oe = drive_oe_q;
	assign o_strap_pullup_en = pullup_q;
	assign o_strap_pulldown_en = pulldown_q;
	assign o_ir_code_output = out_q;
	assign o_resonator_run = pullup_q;
endmodule

// [ir_encoder_defs.svh]
// Constants for the infrared pulse-spacing remote encoder
`ifndef IR_ENCODER_DEFS_SVH
`define IR_ENCODER_DEFS_SVH

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_WORDS 4'h8
`define CTRL_ENABLE_BIT 0
`define CTRL_ENABLE_RESET 1'b1
`define STAT_BUSY_BIT 0
`define STAT_MOD_BIT 1
`define STAT_LONG_BIT 2
`define STAT_ADDR_LSB 4
`define STAT_CMD_LSB 8
`define STAT_TOG_LSB 16

// ----------------------------------------------------------------
// Timing, in oscillator periods unless named otherwise
// ----------------------------------------------------------------
`define CLK_FREQ_HZ 125000000
`define OSC_FREQ_HZ 455000
`define UNIT_OSC 1152
`define ZERO_UNITS 2
`define ONE_UNITS 3
`define WORD_SHORT_OSC 55296
`define WORD_LONG_OSC 59904
`define SCAN_STEP_OSC 4
`define FLASH_HALVES 4'h8
`define MOD_HALVES 4'hf

// ----------------------------------------------------------------
// Matrix and word layout
// ----------------------------------------------------------------
`define NUM_LINES 7
`define STRAP_MODE_LINE 6
`define LAST_STEP 3'h6
`define ADDR_NONE 3'h7
`define TRIPLE_SENSE 3'h7
`define BITS_SHORT 4'hb
`define BITS_LONG 4'hc

`endif

// [ir_encoder_pkg.sv]
// Types shared by the infrared encoder
package ir_encoder_pkg;
	typedef enum logic [4:0] {
		st_standby = 5'b00001,
		st_scan = 5'b00010,
		st_hold = 5'b00100,
		st_pulse = 5'b01000,
		st_gap = 5'b10000
	} tx_state_type;
endpackage

// [in_sync2.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module in_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else if (i_ce) begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule

// [osc_tick_gen.sv]
// Oscillator emulation: half and full period ticks from the system clock
`timescale 1ns/1ps
module osc_tick_gen #(
	parameter int HALF_DIV = 137
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_run,
	output logic o_half_tick,
	output logic o_full_tick
);
	logic [15:0] cnt_q;
	logic phase_q;
	logic half_q;
	logic full_q;

	// Stopped counter restarts in phase, so a word always opens aligned
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 16'h0000;
			phase_q <= 1'b0;
			half_q <= 1'b0;
			full_q <= 1'b0;
		end else if (i_ce) begin
			if (!i_run) begin
				cnt_q <= 16'h0000;
				phase_q <= 1'b0;
				half_q <= 1'b0;
				full_q <= 1'b0;
			end else if (cnt_q == 16'(HALF_DIV - 1)) begin
				cnt_q <= 16'h0000;
				phase_q <= ~phase_q;
				half_q <= 1'b1;
				full_q <= phase_q;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
				half_q <= 1'b0;
				full_q <= 1'b0;
			end
		end
	end

	assign o_half_tick = half_q;
	assign o_full_tick = full_q;
endmodule

// [ir_encoder_sva.sv]
// Port-level assertions for the infrared remote encoder
`timescale 1ns/1ps
`include "ir_encoder_defs.svh"
module ir_encoder_sva (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	input wire logic [`NUM_LINES-1:0] i_matrix_sense_n,
	input wire logic [`NUM_LINES-1:0] o_matrix_drive_out,
	input wire logic [`NUM_LINES-1:0] o_matrix_drive_oe,
	input wire logic o_strap_pullup_en,
	input wire logic o_strap_pulldown_en,
	input wire logic o_ir_code_output,
	input wire logic o_resonator_run
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_pull_exclusive: assert property (o_strap_pullup_en == !o_strap_pulldown_en)
		else $error("strap pulls both on or both off");
	a_run_with_pullup: assert property (o_resonator_run == o_strap_pullup_en)
		else $error("oscillator run differs from active state");
	a_standby_conduct: assert property (o_strap_pulldown_en |-> &o_matrix_drive_oe)
		else $error("driver released in standby");
	a_drive_value_low: assert property (o_matrix_drive_out == '0)
		else $error("open-drain driver value not low");
	a_scan_one_driver: assert property (!(&o_matrix_drive_oe) |-> $onehot(o_matrix_drive_oe))
		else $error("scan drives more than one line");
	a_idle_output_low: assert property (o_strap_pulldown_en |-> !o_ir_code_output)
		else $error("code output high in standby");
	a_no_wake_idle: assert property (
		(o_strap_pulldown_en && (&i_matrix_sense_n)) [*4] |=> o_strap_pulldown_en)
		else $error("woke without key contact");
	a_wake_then_scan: assert property (
		$fell(o_strap_pulldown_en) |-> ##[0:4] !(&o_matrix_drive_oe))
		else $error("no scan after wake");
	a_pulse_whole_half: assert property ($rose(o_ir_code_output) |-> o_ir_code_output [*2])
		else $error("output pulse shorter than half oscillator period");
	a_bus_one_wait: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus answer later than one wait cycle");
endmodule

// [keypad_strap_model.sv]
// Key matrix contacts and address strap wiring
`timescale 1ns/1ps
module keypad_strap_model (
	input wire logic [6:0] i_drive_oe,
	input wire logic i_pullup_en,
	input wire logic i_pulldown_en,
	input wire logic i_key_down,
	input wire logic [2:0] i_key_drv,
	input wire logic [6:0] i_key_senses,
	input wire logic [6:0] i_strap_mask,
	output logic [6:0] o_sense_n,
	output logic o_strap
);
	// contact pulls senses low only through a conducting driver
	assign o_sense_n = (i_key_down && i_drive_oe[i_key_drv]) ? ~i_key_senses : 7'h7f;
	// a conducting strapped driver overrides the switched pulls
	assign o_strap = ((i_strap_mask & i_drive_oe) != 7'h00) ? 1'b0 : (i_pullup_en & ~i_pulldown_en);
endmodule

// [test_ir_remote_pulse_spacing_encoder.sv]
// Self-checking bench for the infrared remote encoder
`timescale 1ns/1ps
`include "ir_encoder_defs.svh"
module test_ir_remote_pulse_spacing_encoder;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, q;
	logic wait_rq, strap, pu, pd, ir, run;
	logic [6:0] sense_n, drv_out, drv_oe;
	logic key_down = 1'b0;
	logic ce = 1'b1;
	logic [2:0] key_drv = 3'h0;
	logic [6:0] key_sen = 7'h00;
	logic [6:0] strap_mask = 7'h00;
	logic [1:0] tog;
	logic tog_known = 1'b0;
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int low_run = 100;
	int edge_q[$];
	int high_q[$];
	int rise_q[$];

	always #4 clk = ~clk;

	// Short counts: t_osc is 4 clocks, a unit 32 clocks
	// Unit kept wide enough that a modulated burst never merges with the next pulse
	ir_remote_pulse_spacing_encoder #(.HALF_DIV(2), .UNIT_OSC(8), .WORD_SHORT_OSC(320),
		.WORD_LONG_OSC(360)) i_ir_remote_pulse_spacing_encoder (
		.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wait_rq), .i_matrix_sense_n(sense_n), .o_matrix_drive_out(drv_out),
		.o_matrix_drive_oe(drv_oe), .i_address_mode_strap_input(strap),
		.o_strap_pullup_en(pu), .o_strap_pulldown_en(pd), .o_ir_code_output(ir),
		.o_resonator_run(run));

	keypad_strap_model i_keypad_strap_model (.i_drive_oe(drv_oe), .i_pullup_en(pu),
		.i_pulldown_en(pd), .i_key_down(key_down), .i_key_drv(key_drv),
		.i_key_senses(key_sen), .i_strap_mask(strap_mask), .o_sense_n(sense_n), .o_strap(strap));

	// --------------------------------
	// Pulse monitor
	// --------------------------------
	// A rise after eight low clocks opens a pulse; burst gaps are shorter
	always @(posedge clk) begin
		cyc++;
		if (ir === 1'b1) begin
			if (low_run >= 8) begin
				edge_q.push_back(cyc);
				high_q.push_back(0);
				rise_q.push_back(0);
			end
			if (low_run > 0 && rise_q.size() > 0)
				rise_q[$] = rise_q[$] + 1;
			if (high_q.size() > 0)
				high_q[$] = high_q[$] + 1;
			low_run = 0;
		end else begin
			low_run++;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk); while (wait_rq !== 1'b0);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// Holds a key for two words, moves the strap meanwhile, then releases
	task automatic press(input logic [2:0] d, input logic [6:0] sm, input logic [6:0] st,
		input logic md, input logic lg, input logic [3:0] ad, input logic [5:0] cmd);
		int nb;
		logic [11:0] w;
		nb = lg ? 12 : 11;
		edge_q.delete();
		high_q.delete();
		rise_q.delete();
		strap_mask <= st;
		key_drv <= d;
		key_sen <= sm;
		key_down <= 1'b1;
		for (int k = 0; k < 5000 && edge_q.size() < 2 * nb + 2; k++) begin
			@(posedge clk);
			if (edge_q.size() > 0)
				strap_mask <= st ^ 7'h01;
		end
		// Release in the last pulse; it must still finish whole
		key_down <= 1'b0;
		repeat (40) @(posedge clk);
		if (tog_known)
			tog = tog + 2'h1;
		else
			tog = {edge_q[1] - edge_q[0] == 96, edge_q[2] - edge_q[1] == 96};
		tog_known = 1'b1;
		w = lg ? {tog, ad, cmd} : {1'b0, tog, ad[2:0], cmd};
		for (int j = 0; j < 2 * nb + 2; j++) begin
			check(rise_q[j], md ? 32'h8 : 32'h1);
			check(high_q[j], 32'h10);
			if (j % (nb + 1) != nb)
				check(edge_q[j + 1] - edge_q[j], w[nb - 1 - j % (nb + 1)] ? 96 : 64);
		end
		check(edge_q[nb + 1] - edge_q[0], lg ? 1440 : 1280);
		bus(1'b0, `REG_STATUS, 32'h0, q);
		check({q[17:16], q[13:8], q[7:4], q[2:0]}, {tog, cmd, ad, lg, md, 1'b1});
		for (int k = 0; k < 3000 && pd !== 1'b1; k++)
			@(posedge clk);
		check({pd, run}, 2'b10);
	endtask

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// --------------------------------
	// Test sequence
	// --------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check({pu, pd, run, ir, drv_oe}, {4'b0100, 7'h7f});
		bus(1'b0, `REG_CTRL, 32'h0, q);
		check(q, 32'h1);
		bus(1'b1, `REG_STATUS, 32'hffffffff, q);
		bus(1'b0, `REG_STATUS, 32'h0, q);
		check(q[0], 1'b0);
		bus(1'b1, 4'hc, 32'hffffffff, q);
		bus(1'b0, 4'hc, 32'h0, q);
		check(q, 32'h0);
		// Clock enable low freezes the synchronisers, so a contact cannot wake
		ce <= 1'b0;
		key_sen <= 7'h01;
		key_down <= 1'b1;
		repeat (50) @(posedge clk);
		check({pd, run}, 2'b10);
		key_down <= 1'b0;
		repeat (4) @(posedge clk);
		ce <= 1'b1;
		press(3'h2, 7'h02, 7'h00, 1'b0, 1'b0, 4'h7, 6'h0a);
		press(3'h5, 7'h60, 7'h52, 1'b1, 1'b1, 4'h5, 6'h3d);
		press(3'h0, 7'h01, 7'h20, 1'b0, 1'b0, 4'h5, 6'h00);
		press(3'h6, 7'h40, 7'h28, 1'b0, 1'b1, 4'hf, 6'h36);
		strap_mask <= 7'h7f;
		repeat (50) @(posedge clk);
		check(pd, 1'b1);
		bus(1'b1, `REG_CTRL, 32'h0, q);
		key_down <= 1'b1;
		repeat (300) @(posedge clk);
		check({pd, ir}, 2'b10);
		key_down <= 1'b0;
		bus(1'b1, `REG_CTRL, 32'h1, q);
		bus(1'b0, `REG_WORDS, 32'h0, q);
		check(q[15:0], 16'h8);
		finish_test();
	end

	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		finish_test();
	end
endmodule

bind ir_remote_pulse_spacing_encoder ir_encoder_sva i_ir_encoder_sva (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_waitrequest(o_avs_waitrequest), .i_matrix_sense_n(i_matrix_sense_n),
	.o_matrix_drive_out(o_matrix_drive_out), .o_matrix_drive_oe(o_matrix_drive_oe),
	.o_strap_pullup_en(o_strap_pullup_en), .o_strap_pulldown_en(o_strap_pulldown_en),
	.o_ir_code_output(o_ir_code_output), .o_resonator_run(o_resonator_run));
